// [hdl/i2c_master_rs_tx.sv]
// master sequencer: repeated start and byte transmit with apb registers
// How it works
// - restart request honoured only when sequencer idle
// - restart drives scl low, then loads baud
// - sda released high one interval, scl low
// - timeout with sda high releases scl, reload
// - sda driven low one interval, scl high
// - request auto-clears, sda left low
// - start flag on bus start; event after timeout
// - collision: sda low at rise, early scl low
// - buffer write sets full flag, starts baud
// - bit shifted after scl low, held interval
// - scl high one interval, sda stable
// - eighth falling edge clears full, frees sda
// - ack captured at ninth rise, low=received
// - after ninth clock flag set, scl held low
//
// Implementation choices: the register addresses and the APB interface to the registers.
module i2c_master_rs_tx #(
    parameter int BAUD_WIDTH = i2c_master_pkg::BAUD_W
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // two-wire bus pins
    input  wire logic        sclIn,
    output logic             sclOut,
    output logic             sclOe,
    input  wire logic        sdaIn,
    output logic             sdaOut,
    output logic             sdaOe,
    // interrupt
    output logic             irq
);

    // state and registers
    i2c_master_pkg::mstate_e state_q;            // sequencer state
    logic [BAUD_WIDTH-1:0]   baudReload_q;       // programmed reload
    logic [BAUD_WIDTH-1:0]   baudCnt_q;          // running interval counter
    logic                    baudRun_q;          // counter active
    logic                    restartReq_q;       // restart_request bit
    logic                    bufFull_q;          // buffer_full_flag
    logic                    ack_status_bit_q;          // ack_status_bit
    logic                    startSeen_q;        // start detected flag
    logic [7:0]              shiftBuf_q;         // shift_buffer
    logic [3:0]              bitCnt_q;           // bits sent in byte
    logic                    sclLow_q;           // drive scl low
    logic                    sdaLow_q;           // drive sda low
    logic [i2c_master_pkg::EV_W-1:0] events_q;   // sticky events
    logic [i2c_master_pkg::EV_W-1:0] mask_q;     // event mask
    logic                    sclPrev_q;          // previous scl sample
    logic                    sdaPrev_q;          // previous sda sample

    // bus access decode
    logic wrAcc;
    logic rdAcc;
    assign wrAcc = psel && penable && pwrite;
    assign rdAcc = psel && penable && !pwrite;

    // address validity check, shared by read and write paths
    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == i2c_master_pkg::CTRL_OFS) || (a == i2c_master_pkg::STATUS_OFS)
              || (a == i2c_master_pkg::BUF_OFS)  || (a == i2c_master_pkg::BAUD_OFS)
              || (a == i2c_master_pkg::IRQ_OFS)  || (a == i2c_master_pkg::MASK_OFS);
    endfunction : mapped

    // events raised this cycle
    logic baudDone;
    logic evSerial;
    logic evColl;
    logic idle;
    logic bufWrite;
    assign baudDone = baudRun_q && (baudCnt_q == '0);
    assign idle     = (state_q == i2c_master_pkg::ST_IDLE)
                   || (state_q == i2c_master_pkg::ST_HOLD);
    assign bufWrite = wrAcc && (paddr == i2c_master_pkg::BUF_OFS) && idle;

    // collision: sda low when scl rises, or scl pulled low before sda goes low
    assign evColl = ((state_q == i2c_master_pkg::ST_RS_SCLHI) && !sclPrev_q && sclIn
                     && !sdaIn)
                 || (((state_q == i2c_master_pkg::ST_RS_SCLHI)
                      || (state_q == i2c_master_pkg::ST_RS_SDALOW))
                     && sclPrev_q && !sclIn && !sdaOe);
    assign evSerial = baudDone && ((state_q == i2c_master_pkg::ST_RS_END)
                                || (state_q == i2c_master_pkg::ST_ACK_HIGH));

    // apb answers in the access cycle, no wait states
    always_ff @(posedge clk) begin
        if (reset) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped(paddr);
        end
    end

    // read data mux, registered at setup phase
    always_ff @(posedge clk) begin
        if (reset) begin
            prdata <= '0;
        end else if (psel && !penable && !pwrite) begin
            if (paddr == i2c_master_pkg::CTRL_OFS) begin
                prdata <= 32'(restartReq_q);
            end else if (paddr == i2c_master_pkg::STATUS_OFS) begin
                prdata <= 32'({!idle, startSeen_q, ack_status_bit_q, bufFull_q});
            end else if (paddr == i2c_master_pkg::BUF_OFS) begin
                prdata <= 32'(shiftBuf_q);
            end else if (paddr == i2c_master_pkg::BAUD_OFS) begin
                prdata <= 32'(baudReload_q);
            end else if (paddr == i2c_master_pkg::IRQ_OFS) begin
                prdata <= 32'(events_q);
            end else if (paddr == i2c_master_pkg::MASK_OFS) begin
                prdata <= 32'(mask_q);
            end else begin
                prdata <= '0;
            end
        end
    end

    // configuration registers
    always_ff @(posedge clk) begin
        if (reset) begin
            baudReload_q <= BAUD_WIDTH'(i2c_master_pkg::BAUD_RST);
            mask_q       <= '0;
        end else if (wrAcc && pready) begin
            if (paddr == i2c_master_pkg::BAUD_OFS) begin
                baudReload_q <= pwdata[BAUD_WIDTH-1:0];
            end else if (paddr == i2c_master_pkg::MASK_OFS) begin
                mask_q <= pwdata[i2c_master_pkg::EV_W-1:0];
            end
        end
    end

    // sticky events: a read clears, a new event in the same cycle wins
    always_ff @(posedge clk) begin
        if (reset) begin
            events_q <= '0;
        end else begin
            events_q <= ((rdAcc && pready && paddr == i2c_master_pkg::IRQ_OFS)
                         ? '0 : events_q) | {evColl, evSerial};
        end
    end

    // interrupt level output
    always_ff @(posedge clk) begin
        if (reset) begin
            irq <= 1'b0;
        end else begin
            irq <= |(events_q & mask_q);
        end
    end

    // line samples for edge detection
    always_ff @(posedge clk) begin
        if (reset) begin
            sclPrev_q <= 1'b1;
            sdaPrev_q <= 1'b1;
        end else begin
            sclPrev_q <= sclIn;
            sdaPrev_q <= sdaIn;
        end
    end

    // start detect: sda falls while scl high; cleared by a buffer write
    always_ff @(posedge clk) begin
        if (reset) begin
            startSeen_q <= 1'b0;
        end else if (sclIn && sclPrev_q && sdaPrev_q && !sdaIn) begin
            startSeen_q <= 1'b1;
        end else if (bufWrite) begin
            startSeen_q <= 1'b0;
        end
    end

    // restart request bit; writes outside idle are dropped
    always_ff @(posedge clk) begin
        if (reset) begin
            restartReq_q <= 1'b0;
        end else if (evColl) begin
            restartReq_q <= 1'b0;
        end else if (evSerial && state_q == i2c_master_pkg::ST_RS_END) begin
            restartReq_q <= 1'b0;
        end else if (wrAcc && pready && paddr == i2c_master_pkg::CTRL_OFS && idle
                     && pwdata[i2c_master_pkg::RESTART_BIT]) begin
            restartReq_q <= 1'b1;
        end
    end

    // shift buffer, full flag, ack capture
    always_ff @(posedge clk) begin
        if (reset) begin
            shiftBuf_q <= '0;
            bufFull_q  <= 1'b0;
            ack_status_bit_q  <= 1'b0;
        end else begin
            if (bufWrite && pready && !restartReq_q) begin
                shiftBuf_q <= pwdata[7:0];
                bufFull_q  <= 1'b1;
            end else if (state_q == i2c_master_pkg::ST_TX_HIGH && baudDone) begin
                shiftBuf_q <= {shiftBuf_q[6:0], 1'b0};
                if (bitCnt_q == 4'(i2c_master_pkg::BITS_PER_BYTE - 1)) begin
                    bufFull_q <= 1'b0;
                end
            end
            if (state_q == i2c_master_pkg::ST_ACK_HIGH && sclIn && !sclPrev_q) begin
                ack_status_bit_q <= sdaIn;
            end
        end
    end

    // baud interval counter; every load restarts a full interval
    always_ff @(posedge clk) begin
        if (reset) begin
            baudCnt_q <= '0;
            baudRun_q <= 1'b0;
        end else if (
            (state_q == i2c_master_pkg::ST_RS_SCLLOW && !sclIn)
         || (state_q == i2c_master_pkg::ST_RS_SCLHI && !sclPrev_q && sclIn)
         || (bufWrite && pready && !restartReq_q)
         || (baudDone && state_q != i2c_master_pkg::ST_RS_END
             && state_q != i2c_master_pkg::ST_ACK_HIGH
             && (state_q != i2c_master_pkg::ST_RS_SCLHI || (sdaIn && sclIn)))) begin
            baudCnt_q <= baudReload_q;
            baudRun_q <= 1'b1;
        end else if (baudDone) begin
            baudRun_q <= 1'b0;
        end else if (baudRun_q) begin
            baudCnt_q <= baudCnt_q - 1'b1;
        end
    end

    // master sequencer
    always_ff @(posedge clk) begin
        if (reset) begin
            state_q  <= i2c_master_pkg::ST_IDLE;
            sclLow_q <= 1'b0;
            sdaLow_q <= 1'b0;
            bitCnt_q <= '0;
        end else if (evColl) begin
            state_q  <= i2c_master_pkg::ST_IDLE;
            sclLow_q <= 1'b0;
            sdaLow_q <= 1'b0;
        end else begin
            case (state_q)
                i2c_master_pkg::ST_IDLE, i2c_master_pkg::ST_HOLD: begin
                    if (restartReq_q) begin
                        sclLow_q <= 1'b1;
                        state_q  <= i2c_master_pkg::ST_RS_SCLLOW;
                    end else if (bufWrite && pready) begin
                        sclLow_q <= 1'b1;
                        sdaLow_q <= !pwdata[7];
                        bitCnt_q <= '0;
                        state_q  <= i2c_master_pkg::ST_TX_LOW;
                    end
                end
                i2c_master_pkg::ST_RS_SCLLOW: begin
                    if (!sclIn) begin
                        sdaLow_q <= 1'b0;
                        state_q  <= i2c_master_pkg::ST_RS_SDAHI;
                    end
                end
                i2c_master_pkg::ST_RS_SDAHI: begin
                    if (baudDone && sdaIn) begin
                        sclLow_q <= 1'b0;
                        state_q  <= i2c_master_pkg::ST_RS_SCLHI;
                    end
                end
                i2c_master_pkg::ST_RS_SCLHI: begin
                    if (baudDone && sdaIn && sclIn) begin
                        sdaLow_q <= 1'b1;
                        state_q  <= i2c_master_pkg::ST_RS_SDALOW;
                    end
                end
                i2c_master_pkg::ST_RS_SDALOW: begin
                    if (baudDone) begin
                        sclLow_q <= 1'b1;
                        state_q  <= i2c_master_pkg::ST_RS_END;
                    end
                end
                i2c_master_pkg::ST_RS_END: begin
                    if (baudDone) begin
                        state_q <= i2c_master_pkg::ST_HOLD;
                    end
                end
                i2c_master_pkg::ST_TX_LOW: begin
                    if (baudDone) begin
                        sclLow_q <= 1'b0;
                        state_q  <= i2c_master_pkg::ST_TX_HIGH;
                    end
                end
                i2c_master_pkg::ST_TX_HIGH: begin
                    if (baudDone) begin
                        sclLow_q <= 1'b1;
                        bitCnt_q <= bitCnt_q + 1'b1;
                        if (bitCnt_q == 4'(i2c_master_pkg::BITS_PER_BYTE - 1)) begin
                            sdaLow_q <= 1'b0;
                            state_q  <= i2c_master_pkg::ST_ACK_LOW;
                        end else begin
                            sdaLow_q <= !shiftBuf_q[6];
                            state_q  <= i2c_master_pkg::ST_TX_LOW;
                        end
                    end
                end
                i2c_master_pkg::ST_ACK_LOW: begin
                    if (baudDone) begin
                        sclLow_q <= 1'b0;
                        state_q  <= i2c_master_pkg::ST_ACK_HIGH;
                    end
                end
                i2c_master_pkg::ST_ACK_HIGH: begin
                    if (baudDone) begin
                        sclLow_q <= 1'b1;
                        state_q  <= i2c_master_pkg::ST_HOLD;
                    end
                end
                default: begin
                    state_q <= i2c_master_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // open-drain pin drive
    always_ff @(posedge clk) begin
        if (reset) begin
            sclOe  <= 1'b0;
            sdaOe  <= 1'b0;
            sclOut <= 1'b0;
            sdaOut <= 1'b0;
        end else begin
            sclOe  <= sclLow_q;
            sdaOe  <= sdaLow_q;
            sclOut <= 1'b0;
            sdaOut <= 1'b0;
        end
    end

    // eighth falling edge leaves full flag clear and sda released
    a_ack_release: assert property (@(posedge clk) disable iff (reset)
        state_q == i2c_master_pkg::ST_ACK_LOW |-> !bufFull_q && !sdaLow_q)
        else $error("full flag or sda held in ack slot");
    // restart ends with sda low and no reload
    a_rs_end: assert property (@(posedge clk) disable iff (reset)
        state_q == i2c_master_pkg::ST_HOLD && $past(state_q) == i2c_master_pkg::ST_RS_END
        |-> sdaLow_q && sclLow_q && !baudRun_q && !restartReq_q)
        else $error("restart end state wrong");
    // hold waits with scl low
    a_hold_scl: assert property (@(posedge clk) disable iff (reset)
        state_q == i2c_master_pkg::ST_HOLD && !restartReq_q |-> sclLow_q && !baudRun_q)
        else $error("clock not suspended");
    // restart write outside idle ignored
    a_rs_ignore: assert property (@(posedge clk) disable iff (reset)
        !idle && !restartReq_q |=> !restartReq_q || $past(idle))
        else $error("restart taken while busy");
    // buffer write sets full flag
    a_buf_full: assert property (@(posedge clk) disable iff (reset)
        bufWrite && pready && !restartReq_q |=> bufFull_q && baudRun_q)
        else $error("buffer write not taken");
    // ack captured at ninth rise
    a_ack_cap: assert property (@(posedge clk) disable iff (reset)
        state_q == i2c_master_pkg::ST_ACK_HIGH && sclIn && !sclPrev_q |=> ack_status_bit_q == $past(sdaIn))
        else $error("ack not captured");
    // serial event raised in restart only after timeout
    a_ev_timing: assert property (@(posedge clk) disable iff (reset)
        $rose(events_q[i2c_master_pkg::EV_SERIAL]) |-> $past(baudDone))
        else $error("event before timeout");
    // sda released high while scl low in restart
    a_rs_sdahi: assert property (@(posedge clk) disable iff (reset)
        state_q == i2c_master_pkg::ST_RS_SDAHI |-> sclLow_q && !sdaLow_q)
        else $error("restart high phase wrong");
endmodule : i2c_master_rs_tx

// [hdl/i2c_master_pkg.sv]
// constants for the two-wire master restart and transmit block
package i2c_master_pkg;
    // register byte offsets
    localparam logic [7:0] CTRL_OFS   = 8'h00; // serial_control_two
    localparam logic [7:0] STATUS_OFS = 8'h04; // serial_status_reg
    localparam logic [7:0] BUF_OFS    = 8'h08; // shift_buffer
    localparam logic [7:0] BAUD_OFS   = 8'h0c; // baud reload value
    localparam logic [7:0] IRQ_OFS    = 8'h10; // sticky event status, read clears
    localparam logic [7:0] MASK_OFS   = 8'h14; // interrupt mask
    // control bit positions
    localparam int RESTART_BIT = 0;
    // status bit positions
    localparam int BF_BIT      = 0;
    localparam int ACK_BIT     = 1;
    localparam int START_BIT   = 2;
    localparam int BUSY_BIT    = 3;
    // event bit positions
    localparam int EV_SERIAL   = 0;
    localparam int EV_COLL     = 1;
    localparam int EV_W        = 2;
    // baud reload defaults
    localparam int BAUD_W          = 16;
    localparam logic [15:0] BAUD_RST = 16'h0010;
    localparam int BITS_PER_BYTE = 8;
    // master sequencer states
    typedef enum logic [3:0] {
        ST_IDLE, ST_RS_SCLLOW, ST_RS_SDAHI, ST_RS_SCLHI, ST_RS_SDALOW, ST_RS_END,
        ST_TX_LOW, ST_TX_HIGH, ST_ACK_LOW, ST_ACK_HIGH, ST_HOLD
    } mstate_e;
endpackage : i2c_master_pkg

// [sim/i2c_slave_model.sv]
// behavioural slave without address matching: collects bits, answers the ninth bit, counts starts
module i2c_slave_model (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       reset,
    // resolved bus lines
    input  wire logic       sclLine,
    input  wire logic       sdaLine,
    // behaviour selection
    input  wire logic       ackEn,    // answer the ninth bit with a low
    input  wire logic       pullLow,  // pull data low while the clock is high: collision
    // observation and drive
    output logic            sdaOe,
    output logic      [7:0] rxByte,
    output logic      [7:0] startCnt
);
    logic       sclQ;   // previous clock line level
    logic       sdaQ;   // previous data line level
    logic       ackQ;   // acknowledge drive
    logic [3:0] bitCnt; // clock rises seen in the current byte
    logic [7:0] shiftQ; // bits collected so far, first one ends on top

    // an unselected slave only ever pulls low; the pull-up does the rest
    assign sdaOe = ackQ | (pullLow & sclLine);

    // line watcher: a start wins over a clock rise in the same cycle
    always_ff @(posedge clk) begin
        sclQ <= sclLine;
        sdaQ <= sdaLine;
        if (reset) begin
            ackQ     <= 1'b0;
            bitCnt   <= 4'h0;
            startCnt <= 8'h00;
        end else if (sclLine && sclQ && sdaQ && !sdaLine) begin
            bitCnt   <= 4'h0;
            startCnt <= startCnt + 8'h01;
        end else if (sclLine && !sclQ) begin
            shiftQ <= {shiftQ[6:0], sdaLine};
            bitCnt <= (bitCnt == 4'h8) ? 4'h0 : bitCnt + 4'h1;
            if (bitCnt == 4'h7) begin
                rxByte <= {shiftQ[6:0], sdaLine};
            end
        end else if (!sclLine && sclQ) begin
            ackQ <= (bitCnt == 4'h8) && ackEn;
        end
    end
endmodule : i2c_slave_model

// [sim/i2c_master_rs_tx_tb_top.sv]
// testbench: apb-driven checks of restart and byte transmit
module i2c_master_rs_tx_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk     = 1'b0;
    logic        reset   = 1'b1;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, sclOe, sdaOe, irq, slvOe, err;
    logic        ackEn   = 1'b1;
    logic        pullLow = 1'b0;
    logic [7:0]  rxByte, startCnt, nStart;
    logic [31:0] d;
    int          n_fail  = 0;
    int          checked = 0;

    // open-drain lines with pull-ups
    wire sclLine = !sclOe;
    wire sdaLine = !(sdaOe | slvOe);

    // 200 MHz clock
    always #2.5 clk = ~clk;

    i2c_master_rs_tx i_i2c_master_rs_tx (.clk(clk), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sclIn(sclLine), .sclOut(), .sclOe(sclOe),
        .sdaIn(sdaLine), .sdaOut(), .sdaOe(sdaOe), .irq(irq));

    i2c_slave_model i_i2c_slave_model (.clk(clk), .reset(reset), .sclLine(sclLine),
        .sdaLine(sdaLine), .ackEn(ackEn), .pullLow(pullLow), .sdaOe(slvOe),
        .rxByte(rxByte), .startCnt(startCnt));

    // verdict and end of run
    task automatic final_report();
        $display("comparisons %0d, mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : final_report

    // one comparison
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // one apb transfer, entered just after a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        int i;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (i == 50) begin
            n_fail++;
            final_report();
        end
        @(posedge clk);
    endtask : apb

    // wait for the interrupt; a hang ends the run
    task automatic waitIrq();
        for (int i = 0; i < 3000; i++) begin
            @(posedge clk);
            if (irq === 1'b1) return;
        end
        n_fail++;
        final_report();
    endtask : waitIrq

    // send one byte and check its whole course
    task automatic sendByte(input logic [7:0] b, input logic ack);
        ackEn <= ack;
        apb(1'b1, i2c_master_pkg::BUF_OFS, {24'h0, b}, d);
        apb(1'b0, i2c_master_pkg::STATUS_OFS, 32'h0, d);
        check(32'(d[i2c_master_pkg::BF_BIT]), 32'h1);
        waitIrq();
        check(32'(rxByte), 32'(b));
        apb(1'b0, i2c_master_pkg::STATUS_OFS, 32'h0, d);
        check(d & 32'h3, {30'h0, ~ack, 1'b0});
        check(32'(sclOe), 32'h1);
        apb(1'b0, i2c_master_pkg::IRQ_OFS, 32'h0, d);
        check(d, 32'h1);
        @(posedge clk);
        check(32'(irq), 32'h0);
    endtask : sendByte

    // main sequence
    initial begin
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        // reset values and an unmapped place
        apb(1'b0, i2c_master_pkg::STATUS_OFS, 32'h0, d);
        check(d, 32'h0);
        apb(1'b0, i2c_master_pkg::BAUD_OFS, 32'h0, d);
        check(d, 32'(i2c_master_pkg::BAUD_RST));
        apb(1'b0, 8'h40, 32'h0, d);
        check(32'(err), 32'h1);
        // short interval keeps the run brief
        apb(1'b1, i2c_master_pkg::BAUD_OFS, 32'h3, d);
        apb(1'b1, i2c_master_pkg::MASK_OFS, 32'h3, d);
        sendByte(8'ha5, 1'b1);
        sendByte(8'h3c, 1'b0);
        // repeated start from the held-low state
        nStart = startCnt;
        apb(1'b1, i2c_master_pkg::CTRL_OFS, 32'h1, d);
        waitIrq();
        apb(1'b0, i2c_master_pkg::CTRL_OFS, 32'h0, d);
        check(d & 32'h1, 32'h0);
        check(32'({sclOe, sdaOe}), 32'h3);
        check(32'(startCnt), 32'(nStart + 8'h01));
        apb(1'b0, i2c_master_pkg::STATUS_OFS, 32'h0, d);
        check(32'(d[i2c_master_pkg::START_BIT]), 32'h1);
        apb(1'b0, i2c_master_pkg::IRQ_OFS, 32'h0, d);
        check(d, 32'h1);
        // restart requested mid-byte must be dropped
        nStart = startCnt;
        ackEn <= 1'b1;
        apb(1'b1, i2c_master_pkg::BUF_OFS, 32'h81, d);
        apb(1'b1, i2c_master_pkg::CTRL_OFS, 32'h1, d);
        waitIrq();
        apb(1'b0, i2c_master_pkg::CTRL_OFS, 32'h0, d);
        check(d & 32'h1, 32'h0);
        check(32'(startCnt), 32'(nStart));
        check(32'(rxByte), 32'h81);
        // masking hides a pending event without clearing it
        apb(1'b1, i2c_master_pkg::MASK_OFS, 32'h0, d);
        @(posedge clk);
        check(32'(irq), 32'h0);
        apb(1'b1, i2c_master_pkg::MASK_OFS, 32'h3, d);
        @(posedge clk);
        check(32'(irq), 32'h1);
        apb(1'b0, i2c_master_pkg::IRQ_OFS, 32'h0, d);
        check(d, 32'h1);
        // collision: slave pulls data low as the restart releases the clock
        pullLow <= 1'b1;
        apb(1'b1, i2c_master_pkg::CTRL_OFS, 32'h1, d);
        waitIrq();
        apb(1'b0, i2c_master_pkg::IRQ_OFS, 32'h0, d);
        check(32'(d[i2c_master_pkg::EV_COLL]), 32'h1);
        check(32'({sclOe, sdaOe}), 32'h0);
        pullLow <= 1'b0;
        final_report();
    end
endmodule : i2c_master_rs_tx_tb_top
